// [cal_pkg.sv]
// Constants for the offset and gain calibration datapath
package cal_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_OFFSET_CAL_LOW  = 8'h05;
  localparam logic [7:0] ADDR_OFFSET_CAL_MID  = 8'h06;
  localparam logic [7:0] ADDR_OFFSET_CAL_HIGH = 8'h07;
  localparam logic [7:0] ADDR_GAIN_CAL_LOW    = 8'h08;
  localparam logic [7:0] ADDR_GAIN_CAL_MID    = 8'h09;
  localparam logic [7:0] ADDR_GAIN_CAL_HIGH   = 8'h0a;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_OFFSET_CAL_LOW  = 8'h00;
  localparam logic [7:0] RST_OFFSET_CAL_MID  = 8'h00;
  localparam logic [7:0] RST_OFFSET_CAL_HIGH = 8'h00;
  localparam logic [7:0] RST_GAIN_CAL_LOW    = 8'h00;
  localparam logic [7:0] RST_GAIN_CAL_MID    = 8'h00;
  localparam logic [7:0] RST_GAIN_CAL_HIGH   = 8'h40;

  // ==========================================================================
  // Datapath
  localparam int DATA_W   = 32;
  localparam int WORD_W   = 24;
  localparam int OFFSET_SHIFT = DATA_W - WORD_W;
  localparam int GAIN_FRAC = 22;
  localparam logic [1:0] FILTER_SINC_ONLY = 2'h1;
  localparam logic [DATA_W-1:0] DATA_MAX = 32'h7fffffff;
  localparam logic [DATA_W-1:0] DATA_MIN = 32'h80000000;

  // ==========================================================================
  // Restart after register write
  localparam int unsigned RESTART_READINGS = 63;
  localparam logic [5:0] RESTART_COUNT = 6'(RESTART_READINGS);

endpackage : cal_pkg

// [cal_scale.sv]
// Offset subtract, gain multiply and saturation stage
module cal_scale
  import cal_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  input  wire logic                     in_valid,
  input  wire logic [DATA_W-1:0]        in_data,
  input  wire logic                     bypass,
  input  wire logic [WORD_W-1:0]        offset_word,
  input  wire logic [WORD_W-1:0]        gain_word,
  output logic                          out_valid,
  output logic [DATA_W-1:0]             out_data
);

  // ==========================================================================
  // Stage 1: subtract aligned offset
  logic signed [DATA_W:0]   diff;
  logic                     s1_valid;
  logic                     s1_bypass;
  logic [DATA_W-1:0]        s1_raw;
  logic [WORD_W-1:0]        s1_gain;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      diff      <= '0;
      s1_valid  <= 1'b0;
      s1_bypass <= 1'b0;
      s1_raw    <= '0;
      s1_gain   <= '0;
    end else if (ce) begin
      s1_valid  <= in_valid;
      s1_bypass <= bypass;
      s1_raw    <= in_data;
      s1_gain   <= gain_word;
      // Offset left-justified, subtracted at 33 bits
      diff <= $signed({in_data[DATA_W-1], in_data})
            - $signed({offset_word[WORD_W-1], offset_word,
                       {OFFSET_SHIFT{1'b0}}});
    end
  end

  // ==========================================================================
  // Stage 2: multiply, normalize, clip
  logic signed [DATA_W+WORD_W+1:0] prod;
  logic signed [DATA_W+WORD_W+1:0] scaled;
  logic [DATA_W-1:0]               next_out;

  always_comb begin
    prod   = diff * $signed({1'b0, s1_gain});
    scaled = prod >>> GAIN_FRAC;
    if (s1_bypass) begin
      next_out = s1_raw;
    end else if (scaled > $signed({{(WORD_W+2){1'b0}}, DATA_MAX})) begin
      next_out = DATA_MAX;
    end else if (scaled < $signed({{(WORD_W+2){1'b1}}, DATA_MIN})) begin
      next_out = DATA_MIN;
    end else begin
      next_out = scaled[DATA_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (ce) begin
      out_valid <= s1_valid;
      if (s1_valid) begin
        out_data <= next_out;
      end
    end
  end

endmodule : cal_scale

// [output_offset_gain_calibration.sv]
// Post-filter offset and gain calibration with its register bytes
module output_offset_gain_calibration
  import cal_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic [7:0]               reg_rdata,
  input  wire logic                cal_offset_load,
  input  wire logic                cal_gain_load,
  input  wire logic [WORD_W-1:0]   cal_word,
  input  wire logic [1:0]          filter_select,
  input  wire logic                filt_valid,
  input  wire logic [DATA_W-1:0]   filt_data,
  output logic                     conv_restart,
  output logic                     out_valid,
  output logic [DATA_W-1:0]        out_data
);

  // ==========================================================================
  // Calibration bytes
  logic [7:0] offset_cal_low;
  logic [7:0] offset_cal_mid;
  logic [7:0] offset_cal_high;
  logic [7:0] gain_cal_low;
  logic [7:0] gain_cal_mid;
  logic [7:0] gain_cal_high;

  // Host write takes priority over a calibration load in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      offset_cal_low  <= RST_OFFSET_CAL_LOW;
      offset_cal_mid  <= RST_OFFSET_CAL_MID;
      offset_cal_high <= RST_OFFSET_CAL_HIGH;
    end else if (ce) begin
      if (reg_wr && reg_addr == ADDR_OFFSET_CAL_LOW) begin
        offset_cal_low <= reg_wdata;
      end else if (cal_offset_load) begin
        offset_cal_low <= cal_word[7:0];
      end
      if (reg_wr && reg_addr == ADDR_OFFSET_CAL_MID) begin
        offset_cal_mid <= reg_wdata;
      end else if (cal_offset_load) begin
        offset_cal_mid <= cal_word[15:8];
      end
      if (reg_wr && reg_addr == ADDR_OFFSET_CAL_HIGH) begin
        offset_cal_high <= reg_wdata;
      end else if (cal_offset_load) begin
        offset_cal_high <= cal_word[23:16];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gain_cal_low  <= RST_GAIN_CAL_LOW;
      gain_cal_mid  <= RST_GAIN_CAL_MID;
      gain_cal_high <= RST_GAIN_CAL_HIGH;
    end else if (ce) begin
      if (reg_wr && reg_addr == ADDR_GAIN_CAL_LOW) begin
        gain_cal_low <= reg_wdata;
      end else if (cal_gain_load) begin
        gain_cal_low <= cal_word[7:0];
      end
      if (reg_wr && reg_addr == ADDR_GAIN_CAL_MID) begin
        gain_cal_mid <= reg_wdata;
      end else if (cal_gain_load) begin
        gain_cal_mid <= cal_word[15:8];
      end
      if (reg_wr && reg_addr == ADDR_GAIN_CAL_HIGH) begin
        gain_cal_high <= reg_wdata;
      end else if (cal_gain_load) begin
        gain_cal_high <= cal_word[23:16];
      end
    end
  end

  // ==========================================================================
  // Word assembly
  logic [WORD_W-1:0] offset_word;
  logic [WORD_W-1:0] gain_word;

  assign offset_word = {offset_cal_high, offset_cal_mid,
                        offset_cal_low};
  assign gain_word   = {gain_cal_high, gain_cal_mid,
                        gain_cal_low};

  // ==========================================================================
  // Register read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      unique case (reg_addr)
        ADDR_OFFSET_CAL_LOW:  reg_rdata <= offset_cal_low;
        ADDR_OFFSET_CAL_MID:  reg_rdata <= offset_cal_mid;
        ADDR_OFFSET_CAL_HIGH: reg_rdata <= offset_cal_high;
        ADDR_GAIN_CAL_LOW:    reg_rdata <= gain_cal_low;
        ADDR_GAIN_CAL_MID:    reg_rdata <= gain_cal_mid;
        ADDR_GAIN_CAL_HIGH:   reg_rdata <= gain_cal_high;
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Conversion restart after any register write
  logic [5:0] restart_left;
  logic       wr_seen;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      restart_left <= 6'h00;
      wr_seen      <= 1'b0;
    end else if (ce) begin
      wr_seen <= reg_wr;
      if (reg_wr) begin
        restart_left <= RESTART_COUNT;
      end else if (filt_valid && restart_left != 6'h00) begin
        restart_left <= restart_left - 6'h01;
      end
    end
  end

  assign conv_restart = wr_seen;

  // ==========================================================================
  // Datapath
  logic sc_valid;
  logic blank;
  logic bypass;

  // Readings inside the restart window are dropped
  assign blank  = reg_wr || restart_left != 6'h00;
  assign bypass = filter_select == FILTER_SINC_ONLY;

  cal_scale u_scale (
    .clk         (clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .in_valid    (filt_valid && !blank),
    .in_data     (filt_data),
    .bypass      (bypass),
    .offset_word (offset_word),
    .gain_word   (gain_word),
    .out_valid   (sc_valid),
    .out_data    (out_data)
  );

  assign out_valid = sc_valid && ce;

endmodule : output_offset_gain_calibration

// [cal_checker.sv]
// Port assertions for the calibration datapath
module cal_checker
  import cal_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              ce,
  input wire logic              reg_wr,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic [7:0]        reg_rdata,
  input wire logic [1:0]        filter_select,
  input wire logic              filt_valid,
  input wire logic [DATA_W-1:0] filt_data,
  input wire logic              conv_restart,
  input wire logic              out_valid,
  input wire logic [DATA_W-1:0] out_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr;
    ce && reg_wr;
  endsequence
  sequence s_map_wr;
    ce && reg_wr && reg_addr >= ADDR_OFFSET_CAL_LOW
    && reg_addr <= ADDR_GAIN_CAL_HIGH;
  endsequence
  a_restart_pulse: assert property (s_wr |=> conv_restart)
    else $error("no restart after write");
  a_restart_cause: assert property (conv_restart |-> $past(reg_wr))
    else $error("restart without write");
  a_drop_after_wr: assert property (
    s_wr ##[1:4] (ce && filt_valid && !reg_wr) |-> ##2 !out_valid)
    else $error("sample not dropped after write");
  a_reg_readback: assert property (
    s_map_wr ##1 (ce && !reg_wr && $stable(reg_addr))
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("register readback wrong");
  a_unmapped_zero: assert property (
    ce && (reg_addr < 8'h05 || reg_addr > 8'h0a) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_valid_cause: assert property (out_valid |-> $past(filt_valid, 2))
    else $error("result without sample");
  a_bypass_pass: assert property (
    out_valid && $past(filter_select, 2) == FILTER_SINC_ONLY
    |-> out_data == $past(filt_data, 2))
    else $error("bypass altered data");
  a_data_hold: assert property (
    $past(rst_n) && !out_valid |-> $stable(out_data))
    else $error("result changed without valid");
endmodule : cal_checker

bind output_offset_gain_calibration cal_checker i_chk (
  .clk           (clk),
  .rst_n         (rst_n),
  .ce            (ce),
  .reg_wr        (reg_wr),
  .reg_addr      (reg_addr),
  .reg_wdata     (reg_wdata),
  .reg_rdata     (reg_rdata),
  .filter_select (filter_select),
  .filt_valid    (filt_valid),
  .filt_data     (filt_data),
  .conv_restart  (conv_restart),
  .out_valid     (out_valid),
  .out_data      (out_data)
);

// [filter_source.sv]
// Filter sample source feeding the calibration stage
module filter_source
  import cal_pkg::*;
(
  input  wire logic              clk,
  output logic                   filt_valid,
  output logic [DATA_W-1:0]      filt_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    filt_valid = 1'b0;
    filt_data  = '0;
  end
  // One-cycle sample, then the data lines show the inverse
  task automatic push(input logic [DATA_W-1:0] d);
    @(posedge clk) #1;
    filt_valid = 1'b1;
    filt_data  = d;
    @(posedge clk) #1;
    filt_valid = 1'b0;
    filt_data  = ~d;
  endtask : push
endmodule : filter_source

// [output_offset_gain_calibration_tb.sv]
// Self-checking bench for the calibration datapath
module output_offset_gain_calibration_tb
  import cal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, rst_n, ce, reg_wr, conv_restart, out_valid;
  logic              cal_offset_load, cal_gain_load, filt_valid;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata;
  logic [1:0]        filter_select;
  logic [WORD_W-1:0] cal_word;
  logic [DATA_W-1:0] filt_data, out_data;
  int                mismatches, n_tests, n_valid = 0;

  output_offset_gain_calibration i_dut (
    .clk             (clk),
    .rst_n           (rst_n),
    .ce              (ce),
    .reg_wr          (reg_wr),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_rdata       (reg_rdata),
    .cal_offset_load (cal_offset_load),
    .cal_gain_load   (cal_gain_load),
    .cal_word        (cal_word),
    .filter_select   (filter_select),
    .filt_valid      (filt_valid),
    .filt_data       (filt_data),
    .conv_restart    (conv_restart),
    .out_valid       (out_valid),
    .out_data        (out_data)
  );
  filter_source i_src (.clk(clk), .filt_valid(filt_valid), .filt_data(filt_data));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (out_valid === 1'b1) n_valid <= n_valid + 1;

  task automatic end_sim();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #1;
    reg_addr = a;
    repeat (2) @(posedge clk);
    #1 check({24'h0, reg_rdata}, {24'h0, exp});
  endtask : rd
  task automatic run(input logic [31:0] d, input logic [31:0] exp);
    int k;
    i_src.push(d);
    for (k = 0; k < 8 && out_valid !== 1'b1; k++) @(posedge clk) #1;
    if (k == 8) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, out_valid, 1'b1);
      end_sim();
    end
    check(out_data, exp);
  endtask : run
  task automatic tcase(input logic [23:0] o, g, input logic [31:0] d, e);
    int n0;
    wr(ADDR_OFFSET_CAL_LOW, o[7:0]);
    wr(ADDR_OFFSET_CAL_MID, o[15:8]);
    wr(ADDR_OFFSET_CAL_HIGH, o[23:16]);
    wr(ADDR_GAIN_CAL_LOW, g[7:0]);
    wr(ADDR_GAIN_CAL_MID, g[15:8]);
    wr(ADDR_GAIN_CAL_HIGH, g[23:16]);
    n0 = n_valid;
    repeat (RESTART_READINGS) i_src.push('0);
    repeat (3) @(posedge clk);
    check(32'(n_valid - n0), 32'h0);
    run(d, e);
  endtask : tcase

  initial begin
    {rst_n, reg_wr, cal_offset_load, cal_gain_load} = 4'h0;
    {reg_addr, reg_wdata, cal_word} = '0;
    ce = 1'b1;
    filter_select = 2'h2;
    mismatches = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(5 + i), (i == 5) ? 8'h40 : 8'h00);
    run(32'h12345678, 32'h12345678);
    tcase(24'h000001, 24'h400000, 32'h0, 32'hffffff00);
    tcase(24'hffffff, 24'h400000, 32'h0, 32'h00000100);
    tcase(24'h7fffff, 24'h400000, 32'h0, 32'h80000100);
    tcase(24'h800000, 24'h400000, 32'h100, 32'h7fffffff);
    tcase(24'h000002, 24'h600000, 32'h400, 32'h00000300);
    tcase(24'h000000, 24'h200000, 32'hffffff01, 32'hffffff80);
    tcase(24'h000000, 24'h000000, 32'h12345678, 32'h0);
    tcase(24'h000000, 24'h800000, 32'h40000000, 32'h7fffffff);
    @(posedge clk) #1;
    cal_word = 24'h000002;
    cal_offset_load = 1'b1;
    @(posedge clk) #1;
    cal_offset_load = 1'b0;
    cal_word = 24'h400000;
    cal_gain_load = 1'b1;
    @(posedge clk) #1;
    cal_gain_load = 1'b0;
    run(32'h400, 32'h200);
    rd(ADDR_OFFSET_CAL_LOW, 8'h02);
    filter_select = FILTER_SINC_ONLY;
    run(32'h400, 32'h400);
    rd(8'h0b, 8'h00);
    wr(8'h0b, 8'hff);
    check({31'h0, conv_restart}, 32'h1);
    @(posedge clk) #1;
    ce = 1'b0;
    wr(ADDR_GAIN_CAL_LOW, 8'h55);
    ce = 1'b1;
    check({31'h0, conv_restart}, 32'h0);
    rd(ADDR_GAIN_CAL_LOW, 8'h00);
    end_sim();
  end
endmodule : output_offset_gain_calibration_tb
